/* File: logic/cap_pkg.sv */
// package: register addresses, field positions and timing counts for the counter array
package cap_pkg;
   localparam int N_MOD = 5;
   // special function register addresses
   localparam logic [7:0] ADDR_CTRL = 8'hd8;
   localparam logic [7:0] ADDR_MODE = 8'hd9;
   localparam logic [7:0] ADDR_MMODE0 = 8'hda;
   localparam logic [7:0] ADDR_CNT_LO = 8'he9;
   localparam logic [7:0] ADDR_CMP_LO0 = 8'hea;
   localparam logic [7:0] ADDR_CNT_HI = 8'hf9;
   localparam logic [7:0] ADDR_CMP_HI0 = 8'hfa;
   // control register fields
   localparam int CTRL_OVF_BIT = 7;
   localparam int CTRL_RUN_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // mode register fields
   localparam int MODE_IDLE_BIT = 7;
   localparam int MODE_TB_HI = 2;
   localparam int MODE_TB_LO = 1;
   localparam int MODE_OVFIE_BIT = 0;
   localparam logic [7:0] MODE_MASK = 8'h87;
   // module mode register fields
   localparam int MM_CMP_EN = 6;
   localparam int MM_MATCH_EN = 3;
   localparam int MM_TOGGLE_EN = 2;
   localparam int MM_PWM_EN = 1;
   localparam int MM_IRQ_EN = 0;
   localparam logic [7:0] MM_MASK = 8'h7f;
   // timebase selections
   localparam logic [1:0] TB_DIV12 = 2'b00;
   localparam logic [1:0] TB_DIV4 = 2'b01;
   localparam logic [1:0] TB_T0 = 2'b10;
   localparam logic [1:0] TB_EXT = 2'b11;
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam logic [7:0] LOW_WRAP = 8'hff;
   localparam logic [15:0] CNT_WRAP = 16'hffff;
endpackage

/* File: logic/cap_timebase.sv */
// timebase: divide-by-12 and divide-by-4 enables, timer 0 ticks, falling edges of the count input
`timescale 1ns/1ps
module cap_timebase (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic [1:0] sel, // timebase select field
   input wire logic advance, // counter may advance (run and not suspended)
   input wire logic t0_ovf, // timer 0 overflow pulse
   input wire logic ext_in, // external count input level
   output logic tick // one-cycle count enable
);
   logic [3:0] div_r, div_nxt;
   logic ext_r, ext_nxt;

   // the divider only runs while counting, so a paused counter resumes mid-period
   always_comb begin
      div_nxt = div_r;
      if (advance) begin
         if ((sel == cap_pkg::TB_DIV12 && div_r == 4'(cap_pkg::DIV_SLOW - 1)) ||
             (sel == cap_pkg::TB_DIV4 && div_r >= 4'(cap_pkg::DIV_FAST - 1)))
            div_nxt = 4'h0;
         else
            div_nxt = div_r + 4'h1;
      end
      ext_nxt = ext_in;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         div_r <= 4'h0;
         ext_r <= 1'b1;
      end else begin
         div_r <= div_nxt;
         ext_r <= ext_nxt;
      end
   end

   // falling edge of the input needs it stable for at least one clock each way
   always_comb begin
      unique case (sel)
         cap_pkg::TB_DIV12: tick = advance && div_r == 4'(cap_pkg::DIV_SLOW - 1);
         cap_pkg::TB_DIV4: tick = advance && div_r >= 4'(cap_pkg::DIV_FAST - 1);
         cap_pkg::TB_T0: tick = advance && t0_ovf;
         cap_pkg::TB_EXT: tick = advance && ext_r && !ext_in;
      endcase
   end

   a_ext_edge: assert property (@(posedge clk) disable iff (srst)
      (sel == cap_pkg::TB_EXT && tick) |-> ($past(ext_in) && !ext_in))
      else $error("external tick without a falling edge");
endmodule

/* File: logic/cap_module.sv */
// one compare module: software timer, toggle output and 8-bit pulse width output
`timescale 1ns/1ps
module cap_module (
   input wire logic clk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic [7:0] mode, // module mode register
   input wire logic [15:0] count, // running counter
   input wire logic tick, // counter advances this cycle
   input wire logic wr_lo, // software writes compare low byte
   input wire logic wr_hi, // software writes compare high byte
   input wire logic [7:0] wdata, // write data
   output logic [15:0] cmp, // compare register
   output logic match, // one-cycle match pulse
   output logic pin // module output pin level
);
   logic [15:0] cmp_r, cmp_nxt;
   logic pin_r, pin_nxt;
   logic cmp_on, pwm_on, tog_on, mat_on, lo_wrap, eq16, eq8;

   assign cmp_on = mode[cap_pkg::MM_CMP_EN];
   assign pwm_on = cmp_on && mode[cap_pkg::MM_PWM_EN];
   assign tog_on = cmp_on && mode[cap_pkg::MM_MATCH_EN] && mode[cap_pkg::MM_TOGGLE_EN];
   assign mat_on = cmp_on && mode[cap_pkg::MM_MATCH_EN] && !pwm_on;
   // compares look at the value the counter takes after this tick
   assign lo_wrap = tick && count[7:0] == cap_pkg::LOW_WRAP;
   assign eq16 = tick && (count + 16'h1) == cmp_r;
   assign eq8 = tick && (count[7:0] + 8'h1) == cmp_r[7:0];
   assign match = mat_on && eq16;

   // compare bytes and output pin
   always_comb begin
      cmp_nxt = cmp_r;
      pin_nxt = pin_r;
      if (wr_lo)
         cmp_nxt[7:0] = wdata;
      if (wr_hi)
         cmp_nxt[15:8] = wdata;
      if (pwm_on) begin
         if (lo_wrap) begin
            cmp_nxt[7:0] = cmp_nxt[15:8];
            pin_nxt = 1'b0;
         end
         // a zero duty byte matches at wrap; set wins so full duty stays high
         if (eq8)
            pin_nxt = 1'b1;
      end else if (tog_on && eq16) begin
         pin_nxt = !pin_r;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cmp_r <= 16'h0000;
         pin_r <= 1'b0;
      end else begin
         cmp_r <= cmp_nxt;
         pin_r <= pin_nxt;
      end
   end

   assign cmp = cmp_r;
   assign pin = pin_r;

   a_toggle_hit: assert property (@(posedge clk) disable iff (srst)
      (tog_on && !pwm_on && eq16) |=> (pin != $past(pin)))
      else $error("toggle output did not invert on match");
   a_pwm_reload: assert property (@(posedge clk) disable iff (srst)
      (pwm_on && lo_wrap && !wr_hi) |=> (cmp[7:0] == $past(cmp[15:8])))
      else $error("low compare byte not reloaded at wrap");
   a_pwm_low: assert property (@(posedge clk) disable iff (srst)
      (pwm_on && lo_wrap && !eq8) |=> !pin)
      else $error("pulse output not low after low byte wrap");
endmodule

/* File: logic/cap_top.sv */
// counter array top: control and mode registers, 16-bit counter, five compare modules
// What this block does
// - software-timer mode sets module flag on 16-bit counter/compare equality
// - module flags are never cleared by hardware; only a software write clears them
// - comparator enable plus match enable selects software-timer mode
// - high-speed output mode inverts the module pin on each 16-bit match
// - toggle, match and comparator enables together select high-speed output mode
// - pulse mode drives pin high when counter low byte equals compare low byte
// - pulse mode drives pin low when counter low byte overflows, unless the compare low byte is zero
// - at low byte wrap, compare high byte is copied into compare low byte
// - comparator enable plus pulse enable selects pulse-width mode
// - each module makes its own pulse output, period set by the timebase
// - reading the counter low byte latches the high byte for a later read
// - counter reads never stop, delay or alter counting
// - timebase field: 00 clock/12, 01 clock/4, 10 timer 0 overflow
// - timebase field 11 counts falling edges of the external count input
// - counter wrap from 0xffff to 0x0000 sets the overflow flag
// - overflow request only while its enable and flag are set; software clears
// - with idle control clear, the array keeps running during core idle
// - run control bit 6: 0 stops the counter, 1 runs it
// - control register: overflow bit 7, run bit 6, module flags 4..0, bit 5 zero
// - a 16-bit match sets the module flag; enabled flag requests service
// - with idle control set, the array is suspended during core idle
// - mode register: timebase bits 2..1, overflow enable bit 0, idle bit 7
`timescale 1ns/1ps
module cap_top #(
   parameter int N = cap_pkg::N_MOD // number of compare modules
) (
   input wire logic clk, // system clock, 100 MHz
   input wire logic srst, // synchronous reset, active high
   input wire logic [7:0] sfr_addr, // register address
   input wire logic sfr_wr, // write strobe, one cycle
   input wire logic sfr_rd, // read strobe, one cycle
   input wire logic [7:0] sfr_wdata, // write data
   output logic [7:0] sfr_rdata, // read data, registered
   input wire logic core_idle, // processor core in idle mode
   input wire logic t0_ovf, // timer 0 overflow pulse
   input wire logic external_count_input, // external count input level
   output logic [N-1:0] module_output_pin, // module output pins
   output logic irq // combined interrupt request, level
);
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] mode_r, mode_nxt;
   logic [7:0] mm_r [N], mm_nxt [N];
   logic [15:0] cnt_r, cnt_nxt;
   logic [7:0] snap_r, snap_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [15:0] cmp [N];
   logic [N-1:0] match, wr_lo, wr_hi, irq_mod;
   logic tick, advance, suspended;

   // offset of an address within a five-register bank, or n when outside it
   function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      if (a >= base && d < 8'(N))
         return int'(d);
      return N;
   endfunction

   assign suspended = mode_r[cap_pkg::MODE_IDLE_BIT] && core_idle;
   assign advance = ctrl_r[cap_pkg::CTRL_RUN_BIT] && !suspended;

   cap_timebase u_tb (
      .clk(clk),
      .srst(srst),
      .sel(mode_r[cap_pkg::MODE_TB_HI:cap_pkg::MODE_TB_LO]),
      .advance(advance),
      .t0_ovf(t0_ovf),
      .ext_in(external_count_input),
      .tick(tick)
   );

   // one compare unit per module, each with its own pin
   generate
      for (genvar i = 0; i < N; i++) begin : g_mod
         assign wr_lo[i] = sfr_wr && bank_idx(sfr_addr, cap_pkg::ADDR_CMP_LO0) == i;
         assign wr_hi[i] = sfr_wr && bank_idx(sfr_addr, cap_pkg::ADDR_CMP_HI0) == i;
         assign irq_mod[i] = ctrl_r[i] && mm_r[i][cap_pkg::MM_IRQ_EN];
         cap_module u_mod (
            .clk(clk),
            .srst(srst),
            .mode(mm_r[i]),
            .count(cnt_r),
            .tick(tick),
            .wr_lo(wr_lo[i]),
            .wr_hi(wr_hi[i]),
            .wdata(sfr_wdata),
            .cmp(cmp[i]),
            .match(match[i]),
            .pin(module_output_pin[i])
         );
      end
   endgenerate

   // registers and counter; hardware set beats a software clear in the same cycle
   always_comb begin
      ctrl_nxt = ctrl_r;
      mode_nxt = mode_r;
      mm_nxt = mm_r;
      cnt_nxt = cnt_r;
      snap_nxt = snap_r;
      if (sfr_wr) begin
         if (sfr_addr == cap_pkg::ADDR_CTRL)
            ctrl_nxt = sfr_wdata & {3'b110, 5'(2 ** N - 1)};
         if (sfr_addr == cap_pkg::ADDR_MODE)
            mode_nxt = sfr_wdata & cap_pkg::MODE_MASK;
         for (int i = 0; i < N; i++)
            if (bank_idx(sfr_addr, cap_pkg::ADDR_MMODE0) == i)
               mm_nxt[i] = sfr_wdata & cap_pkg::MM_MASK;
         // a direct counter write is allowed; software should stop it first
         if (sfr_addr == cap_pkg::ADDR_CNT_LO)
            cnt_nxt[7:0] = sfr_wdata;
         if (sfr_addr == cap_pkg::ADDR_CNT_HI)
            cnt_nxt[15:8] = sfr_wdata;
      end
      if (tick)
         cnt_nxt = cnt_r + 16'h1;
      if (tick && cnt_r == cap_pkg::CNT_WRAP)
         ctrl_nxt[cap_pkg::CTRL_OVF_BIT] = 1'b1;
      for (int i = 0; i < N; i++)
         if (match[i])
            ctrl_nxt[i] = 1'b1;
      // snapshot taken from the live count, reading never touches the counter
      if (sfr_rd && sfr_addr == cap_pkg::ADDR_CNT_LO)
         snap_nxt = cnt_r[15:8];
   end

   // read multiplexer, unmapped addresses read zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (sfr_rd) begin
         rdata_nxt = 8'h00;
         if (sfr_addr == cap_pkg::ADDR_CTRL)
            rdata_nxt = ctrl_r;
         if (sfr_addr == cap_pkg::ADDR_MODE)
            rdata_nxt = mode_r;
         if (sfr_addr == cap_pkg::ADDR_CNT_LO)
            rdata_nxt = cnt_r[7:0];
         if (sfr_addr == cap_pkg::ADDR_CNT_HI)
            rdata_nxt = snap_r;
         for (int i = 0; i < N; i++) begin
            if (bank_idx(sfr_addr, cap_pkg::ADDR_MMODE0) == i)
               rdata_nxt = mm_r[i];
            if (bank_idx(sfr_addr, cap_pkg::ADDR_CMP_LO0) == i)
               rdata_nxt = cmp[i][7:0];
            if (bank_idx(sfr_addr, cap_pkg::ADDR_CMP_HI0) == i)
               rdata_nxt = cmp[i][15:8];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= cap_pkg::CTRL_RESET;
         mode_r <= 8'h00;
         for (int i = 0; i < N; i++)
            mm_r[i] <= 8'h00;
         cnt_r <= 16'h0000;
         snap_r <= 8'h00;
         rdata_r <= 8'h00;
      end else begin
         ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;
         mm_r <= mm_nxt;
         cnt_r <= cnt_nxt;
         snap_r <= snap_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign sfr_rdata = rdata_r;
   // one request line for the whole array
   assign irq = (ctrl_r[cap_pkg::CTRL_OVF_BIT] && mode_r[cap_pkg::MODE_OVFIE_BIT]) ||
                (|irq_mod);

   sequence s_wrap;
      tick && cnt_r == cap_pkg::CNT_WRAP;
   endsequence
   sequence s_flag_up;
      ctrl_r[cap_pkg::CTRL_OVF_BIT] && cnt_r == 16'h0000;
   endsequence

   a_ovf_set: assert property (@(posedge clk) disable iff (srst)
      s_wrap |=> s_flag_up)
      else $error("overflow flag not set on counter wrap");
   a_ovf_sticky: assert property (@(posedge clk) disable iff (srst)
      (ctrl_r[cap_pkg::CTRL_OVF_BIT] && !sfr_wr) |=> ctrl_r[cap_pkg::CTRL_OVF_BIT])
      else $error("overflow flag cleared without a write");
   a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
      (ctrl_r[0] && !(sfr_wr && sfr_addr == cap_pkg::ADDR_CTRL)) |=> ctrl_r[0])
      else $error("module flag cleared by hardware");
   a_match_flag: assert property (@(posedge clk) disable iff (srst)
      match[0] |=> ctrl_r[0])
      else $error("module flag not set on match");
   a_run_hold: assert property (@(posedge clk) disable iff (srst)
      (!ctrl_r[cap_pkg::CTRL_RUN_BIT] && !sfr_wr) |=> $stable(cnt_r))
      else $error("counter moved while stopped");
   a_idle_hold: assert property (@(posedge clk) disable iff (srst)
      (suspended && !sfr_wr) [*2] |-> $stable(cnt_r))
      else $error("counter moved while suspended in idle");
   a_snap_read: assert property (@(posedge clk) disable iff (srst)
      (sfr_rd && sfr_addr == cap_pkg::ADDR_CNT_LO) ##1
      (sfr_rd && sfr_addr == cap_pkg::ADDR_CNT_HI) |=>
      sfr_rdata == $past(cnt_r[15:8], 2))
      else $error("high byte read does not match snapshot");
   a_read_count: assert property (@(posedge clk) disable iff (srst)
      (sfr_rd && !sfr_wr && tick) |=> cnt_r == $past(cnt_r) + 16'h1)
      else $error("counter disturbed by a read");
   a_irq_mask: assert property (@(posedge clk) disable iff (srst)
      (mm_r[0] == 8'h00 && mode_r[cap_pkg::MODE_OVFIE_BIT] == 1'b0 && irq_mod == '0) |-> !irq)
      else $error("request raised with everything masked");
   a_bit5_zero: assert property (@(posedge clk) disable iff (srst)
      !ctrl_r[5])
      else $error("control bit 5 not zero");
endmodule

/* File: dv/cap_ext_model.sv */
// partner model: external source of falling edges on the count input
`timescale 1ns/1ps
module cap_ext_model (
   input wire logic clk, // system clock
   output logic ext_in // count input level, idles high
);
   initial ext_in = 1'b1;
   // low two cycles then high three, so edges never come faster than clk/5
   task automatic falls(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk) ext_in = 1'b0;
         repeat (2) @(negedge clk);
         ext_in = 1'b1;
         repeat (2) @(negedge clk);
      end
   endtask
endmodule

/* File: dv/tb_top.sv */
// testbench: register map, timebases, snapshot, overflow and compare modes
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cap_row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic core_idle = 1'b0;
   logic t0_ovf = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic ext_in;
   logic [4:0] pins;
   logic irq;
   logic [7:0] va;
   logic [7:0] vb;
   int fail_count = 0;
   int num_checks = 0;
   int hi2;
   int hi3;
   cap_row_t rows [7];
   cap_row_t mods [5];

   // 100 MHz system clock
   always #5 clk = ~clk;

   cap_top u_dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .core_idle(core_idle), .t0_ovf(t0_ovf), .external_count_input(ext_in),
      .module_output_pin(pins), .irq(irq));
   cap_ext_model u_ext (.clk(clk), .ext_in(ext_in));

   // write: strobe held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   // read: data taken one and a half cycles after the read edge, it holds till the next read
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      @(negedge clk);
      v = sfr_rdata;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // read edges of the two samples lie n+3 cycles apart
   task automatic rate(input int n, input logic [7:0] e);
      rd(cap_pkg::ADDR_CNT_LO, va);
      repeat (n) @(negedge clk);
      rd(cap_pkg::ADDR_CNT_LO, vb);
      chk("count step", e, 8'(vb - va));
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // watchdog: the whole run needs well under 60 us
   initial begin
      #200us;
      fail_count++;
      report_and_stop();
   end

   initial begin
      rows = '{'{cap_pkg::ADDR_CTRL, 8'h20, 8'h00}, '{cap_pkg::ADDR_MODE, 8'hff, 8'h87},
         '{cap_pkg::ADDR_MMODE0, 8'hff, 8'h7f}, '{cap_pkg::ADDR_MMODE0 + 8'h04, 8'h80, 8'h00},
         '{cap_pkg::ADDR_CMP_HI0 + 8'h01, 8'ha5, 8'ha5},
         '{cap_pkg::ADDR_CMP_LO0 + 8'h04, 8'h3c, 8'h3c}, '{8'hc0, 8'h55, 8'h00}};
      mods = '{'{8'h10, 8'h00, 8'h49}, '{8'h20, 8'h00, 8'h4c}, '{8'h80, 8'h40, 8'h42},
         '{8'hc0, 8'hc0, 8'h42}, '{8'h08, 8'h00, 8'h40}};
      repeat (6) @(negedge clk);
      srst = 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, va);
         chk("register row", rows[i].e, va);
      end
      // second reset in mid-run must bring every register back to zero
      srst = 1'b1;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      foreach (rows[i]) begin
         rd(rows[i].a, va);
         chk("reset value", 8'h00, va);
      end
      chk("reset pins", 5'h00, pins);
      chk("reset irq", 1'b0, irq);
      // timebase selections, counter reads do not disturb counting
      wr(cap_pkg::ADDR_MODE, 8'h02);
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      rate(37, 8'd10);
      wr(cap_pkg::ADDR_MODE, 8'h00);
      rate(45, 8'd4);
      wr(cap_pkg::ADDR_MODE, 8'h04);
      rd(cap_pkg::ADDR_CNT_LO, va);
      repeat (3) begin
         @(negedge clk) t0_ovf = 1'b1;
         @(negedge clk) t0_ovf = 1'b0;
      end
      rd(cap_pkg::ADDR_CNT_LO, vb);
      chk("t0 ticks", 8'd3, 8'(vb - va));
      wr(cap_pkg::ADDR_MODE, 8'h06);
      rd(cap_pkg::ADDR_CNT_LO, va);
      u_ext.falls(3);
      rd(cap_pkg::ADDR_CNT_LO, vb);
      chk("ext ticks", 8'd3, 8'(vb - va));
      // core idle only stops the array when suspension is asked for
      core_idle = 1'b1;
      wr(cap_pkg::ADDR_MODE, 8'h02);
      rate(37, 8'd10);
      wr(cap_pkg::ADDR_MODE, 8'h82);
      rate(37, 8'd0);
      core_idle = 1'b0;
      wr(cap_pkg::ADDR_MODE, 8'h02);
      wr(cap_pkg::ADDR_CTRL, 8'h00);
      rate(37, 8'd0);
      // high byte snapshot taken when the low byte is read
      wr(cap_pkg::ADDR_CNT_LO, 8'hf0);
      wr(cap_pkg::ADDR_CNT_HI, 8'h12);
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      rd(cap_pkg::ADDR_CNT_LO, va);
      repeat (400) @(negedge clk);
      rd(cap_pkg::ADDR_CNT_HI, vb);
      chk("high snapshot", 8'h12, vb);
      rd(cap_pkg::ADDR_CNT_LO, va);
      rd(cap_pkg::ADDR_CNT_HI, vb);
      chk("high relatched", 8'h13, vb);
      // back-to-back low then high reads, the usual software pair
      @(negedge clk);
      sfr_addr = cap_pkg::ADDR_CNT_LO;
      sfr_rd = 1'b1;
      @(negedge clk);
      va = sfr_rdata;
      sfr_addr = cap_pkg::ADDR_CNT_HI;
      @(negedge clk);
      sfr_rd = 1'b0;
      vb = sfr_rdata;
      chk("paired read", 8'h13, vb);
      // overflow flag, masked then enabled request, software clear
      wr(cap_pkg::ADDR_CTRL, 8'h00);
      wr(cap_pkg::ADDR_CNT_LO, 8'hfe);
      wr(cap_pkg::ADDR_CNT_HI, 8'hff);
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      repeat (20) @(negedge clk);
      rd(cap_pkg::ADDR_CTRL, va);
      chk("overflow flag", 8'hc0, va);
      chk("masked irq", 1'b0, irq);
      wr(cap_pkg::ADDR_MODE, 8'h03);
      chk("overflow irq", 1'b1, irq);
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      chk("cleared irq", 1'b0, irq);
      wr(cap_pkg::ADDR_MODE, 8'h02);
      // timer, toggle, two pulse modules and one with no mode
      wr(cap_pkg::ADDR_CTRL, 8'h00);
      wr(cap_pkg::ADDR_CNT_LO, 8'h00);
      wr(cap_pkg::ADDR_CNT_HI, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(cap_pkg::ADDR_CMP_LO0 + 8'(i), mods[i].a);
         wr(cap_pkg::ADDR_CMP_HI0 + 8'(i), mods[i].d);
         wr(cap_pkg::ADDR_MMODE0 + 8'(i), mods[i].e);
      end
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      repeat (200) @(negedge clk);
      rd(cap_pkg::ADDR_CTRL, va);
      chk("match flags", 8'h43, va);
      chk("module irq", 1'b1, irq);
      chk("first match pins", 5'h02, pins);
      // pulse duty after the low-byte wrap has reloaded the compare low byte
      repeat (1100) @(negedge clk);
      rd(cap_pkg::ADDR_CMP_LO0 + 8'h02, va);
      chk("reloaded low", 8'h40, va);
      hi2 = 0;
      hi3 = 0;
      repeat (1024) begin
         @(negedge clk);
         hi2 += pins[2];
         hi3 += pins[3];
      end
      chk("pulse2 high", 16'd768, 16'(hi2));
      chk("pulse3 high", 16'd256, 16'(hi3));
      rd(cap_pkg::ADDR_CTRL, va);
      chk("flags kept", 8'h43, va);
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      rd(cap_pkg::ADDR_CTRL, va);
      chk("flags cleared", 8'h40, va);
      chk("irq idle", 1'b0, irq);
      // a second match toggles the fast output back
      wr(cap_pkg::ADDR_CTRL, 8'h00);
      wr(cap_pkg::ADDR_CNT_LO, 8'h00);
      wr(cap_pkg::ADDR_CNT_HI, 8'h00);
      wr(cap_pkg::ADDR_CTRL, 8'h40);
      repeat (200) @(negedge clk);
      chk("toggle back", 1'b0, pins[1]);
      rd(cap_pkg::ADDR_CTRL, va);
      chk("flags again", 8'h43, va);
      report_and_stop();
   end
endmodule
